//--- core/slp_defs.svh
/*
  constants of the serial link parallel port: widths, timing figures, cycle counts.
  assumes a 25 MHz main clock; included by the package and by the port module.
*/
`ifndef SLP_DEFS_SVH
`define SLP_DEFS_SVH

`define SLP_WORD_W 36
`define SLP_CNT_W 4
`define SLP_OPER_W 11
`define SLP_PAR_ODD 1'b0

// ----------------------------------------
// timing figures
// ----------------------------------------
`define SLP_MCLK_PS 40000
`define SLP_FETCH_NORM_PS 30300
`define SLP_FETCH_MARK_PS 36000
`define SLP_VALID_WIN_PS 18000
`define SLP_OPER_US 50
`define SLP_PARITY_FAULT_N_PS 3000

// ----------------------------------------
// derived cycle counts
// ----------------------------------------
`define SLP_NORM_RAW (`SLP_FETCH_NORM_PS / `SLP_MCLK_PS)
`define SLP_NORM_CYC ((`SLP_NORM_RAW < 2) ? 2 : `SLP_NORM_RAW)
`define SLP_MARK_RAW ((`SLP_FETCH_MARK_PS + `SLP_MCLK_PS - 1) / `SLP_MCLK_PS)
`define SLP_MARK_CYC ((`SLP_MARK_RAW > `SLP_NORM_CYC) ? `SLP_MARK_RAW : `SLP_NORM_CYC + 1)
`define SLP_VALID_RAW ((`SLP_VALID_WIN_PS + `SLP_MCLK_PS - 1) / `SLP_MCLK_PS)
`define SLP_VALID_CYC ((`SLP_VALID_RAW < 1) ? 1 : `SLP_VALID_RAW)
`define SLP_OPER_CYC ((`SLP_OPER_US * 1000000 + `SLP_MCLK_PS - 1) / `SLP_MCLK_PS)
`define SLP_PARITY_FAULT_N_RAW (`SLP_PARITY_FAULT_N_PS / `SLP_MCLK_PS)
`define SLP_PARITY_FAULT_N_CYC ((`SLP_PARITY_FAULT_N_RAW < 1) ? 1 : `SLP_PARITY_FAULT_N_RAW)

`endif

//--- core/slp_pkg.sv
/*
  types of the serial link parallel port.
  assumes slp_defs.svh on the include path.
*/
package slp_pkg;
  `include "slp_defs.svh"

  typedef enum logic [1:0] {
    SLP_SINGLE = 2'b01,
    SLP_BURST  = 2'b10
  } slp_mode_t;

  // main clock domain state
  typedef struct packed {
    logic                   fclk;
    logic [`SLP_CNT_W-1:0]  fcnt;
    logic [`SLP_CNT_W-1:0]  flen;
    logic                   mark_pend;
    logic                   mark_prev;
    slp_mode_t              mode;
    logic                   cap_vld;
    logic [`SLP_WORD_W-1:0] cap_word;
    logic                   cap_par;
    logic [`SLP_OPER_W-1:0] oper_cnt;
    logic                   oper;
    logic                   tx_req;
    logic                   tx_busy;
    logic                   rx_ack;
    logic                   orun;
    logic [`SLP_CNT_W-1:0]  ocnt;
    logic [`SLP_CNT_W-1:0]  olen;
    logic                   oclk;
    logic [`SLP_WORD_W-1:0] rx_word;
    logic                   rx_par;
    logic                   mark_out;
    logic [`SLP_CNT_W-1:0]  parity_fault_n_cnt;
    logic                   sync_n;
    logic                   sync_pend;
  } slp_mst_t;

  // link clock domain state
  typedef struct packed {
    logic                   tx_ack;
    logic [`SLP_WORD_W-1:0] tx_word;
    logic                   tx_par;
    logic                   tx_mark;
    logic                   tx_stb;
    logic                   rx_req;
    logic                   rx_busy;
    logic [`SLP_WORD_W-1:0] h_word;
    logic                   h_par;
    logic                   h_mark;
    logic                   h_hdr;
  } slp_lst_t;
endpackage

//--- core/slp_sync3.sv
/*
  three-flop synchroniser for one level; output follows once stages two and three agree.
  assumes an asynchronous active-low reset; resets to zero.
*/
`timescale 1ns/1ns
module slp_sync3 (
  input  wire logic clk_in,    // destination clock
  input  wire logic rst_n_in,  // async reset, active low
  input  wire logic d_in,      // level from another domain
  output logic      q_out      // filtered level
);
  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic q;
  } slp_sync_t;

  slp_sync_t s_q;
  slp_sync_t s_d;

  always_comb begin
    s_d   = s_q;
    s_d.a = d_in;
    s_d.b = s_q.a;
    s_d.c = s_q.b;
    if (s_q.b == s_q.c) begin
      s_d.q = s_q.c;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_out = s_q.q;
endmodule

//--- core/slp_buf2.sv
/*
  small flop buffer with valid and ready on both sides; DEPTH a power of two.
  assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
module slp_buf2 #(
  parameter int W     = 38,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_in,        // clock
  input  wire logic         rst_n_in,      // async reset, active low
  input  wire logic         in_valid_in,   // word offered
  output logic              in_ready_out,  // room for a word
  input  wire logic [W-1:0] in_data_in,    // word in
  output logic              out_valid_out, // word held
  input  wire logic         out_ready_in,  // consumer takes head
  output logic [W-1:0]      out_data_out   // head word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } slp_buf_t;

  slp_buf_t b_q;
  slp_buf_t b_d;
  logic     push;
  logic     pop;

  assign in_ready_out  = (b_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_out = (b_q.cnt != '0);
  assign out_data_out  = b_q.mem[b_q.rp];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_comb begin
    b_d = b_q;
    if (push) begin
      b_d.mem[b_q.wp] = in_data_in;
      b_d.wp          = b_q.wp + 1'b1;
    end
    if (pop) begin
      b_d.rp = b_q.rp + 1'b1;
    end
    if (push && !pop) begin
      b_d.cnt = b_q.cnt + 1'b1;
    end else if (pop && !push) begin
      b_d.cnt = b_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      b_q <= '0;
    end else begin
      b_q <= b_d;
    end
  end
endmodule

//--- core/slp_port.sv
/*
  parallel user port of a serial link chipset: transmit fetch clock side and
  receive output clock side, with a handshake crossing to the link clock.
  assumes user logic runs on the fetch clock made here, and a serial core on LINK_CLK_IN.
*/
// What this block does
// - burst: sampled valid low ends burst
// - single: sampled valid high enters burst
// - fetch clock runs normal period without marker
// - marker stretches exactly one fetch cycle
// - output clock normal period, data at rise
// - marked word toggles marker output, longer cycle
// - operational after lock and reset 50 us
// - corrupt word pulses parity fault low
// - corrupt word: sync loss at next edge
// - corrupt header: sync loss at its edge
// - corrupt header also pulses parity fault
// - word registered on rising fetch edge
`timescale 1ns/1ns
`include "slp_defs.svh"
module slp_port
  import slp_pkg::*;
(
  input  wire logic                   MCLK_IN,               // main clock, 25 MHz
  input  wire logic                   RST_N_IN,              // async reset, active low
  input  wire logic                   LINK_CLK_IN,           // serial core word clock
  input  wire logic                   LOCK_IN,               // pll lock pin
  input  wire logic [`SLP_WORD_W-1:0] PARALLEL_WORD_IN,      // user word
  input  wire logic                   PARITY_IN,             // user parity
  input  wire logic                   VALID_IN,              // user valid strobe
  input  wire logic                   MARKER_INPUT_IN,       // user marker
  output logic                        TX_FETCH_CLOCK_OUT,    // fetch clock to user
  output logic                        TX_OPER_OUT,           // transmitter operational
  output logic [`SLP_WORD_W-1:0]      TX_WORD_OUT,           // word to serial core
  output logic                        TX_PARITY_OUT,         // its parity
  output logic                        TX_MARK_OUT,           // its marker
  output logic                        TX_STROBE_OUT,         // one link cycle per word
  input  wire logic [`SLP_WORD_W-1:0] RX_WORD_IN,            // word from serial core
  input  wire logic                   RX_PARITY_IN,          // its parity
  input  wire logic                   RX_MARK_IN,            // its marker
  input  wire logic                   RX_HEADER_IN,          // word is a frame header
  input  wire logic                   RX_STROBE_IN,          // word offered
  output logic                        RX_READY_OUT,          // word taken when high
  output logic                        RX_OUTPUT_CLOCK_OUT,   // output clock to user
  output logic [`SLP_WORD_W-1:0]      RX_PARALLEL_WORD_OUT,  // received word
  output logic                        RX_PARITY_OUT,         // received parity
  output logic                        MARKER_OUTPUT_OUT,     // toggles per marked word
  output logic                        PARITY_FAULT_N_OUT,    // parity fault, active low
  output logic                        SYNC_LOSS_N_OUT        // sync lost, active low
);
  localparam int CW = `SLP_CNT_W;
  localparam int OW = `SLP_OPER_W;
  localparam int BW = `SLP_WORD_W + 2;
  localparam logic [CW-1:0] NORM_C  = CW'(`SLP_NORM_CYC);
  localparam logic [CW-1:0] MARK_C  = CW'(`SLP_MARK_CYC);
  localparam logic [CW-1:0] VALID_C = CW'(`SLP_VALID_CYC);
  localparam logic [CW-1:0] PARITY_FAULT_N_C  = CW'(`SLP_PARITY_FAULT_N_CYC);
  localparam logic [OW-1:0] OPER_C  = OW'(`SLP_OPER_CYC);

  slp_mst_t m_q;
  slp_mst_t m_d;
  slp_lst_t l_q;
  slp_lst_t l_d;

  logic          lock_s;
  logic          tx_ack_s;
  logic          rx_req_s;
  logic          tx_req_s;
  logic          rx_ack_s;
  logic          buf_in_valid;
  logic          buf_in_ready;
  logic [BW-1:0] buf_in_data;
  logic          head_valid;
  logic          head_ready;
  logic [BW-1:0] head_data;
  logic          f_end;
  logic          f_wrap;
  logic          mark_rise;
  logic          o_free;
  logic          rx_new;
  logic          rx_bad;

  // ----------------------------------------
  // crossings
  // ----------------------------------------
  slp_sync3 u_lock (
    .clk_in   (MCLK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     (LOCK_IN),
    .q_out    (lock_s)
  );
  slp_sync3 u_txack (
    .clk_in   (MCLK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     (l_q.tx_ack),
    .q_out    (tx_ack_s)
  );
  slp_sync3 u_rxreq (
    .clk_in   (MCLK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     (l_q.rx_req),
    .q_out    (rx_req_s)
  );
  slp_sync3 u_txreq (
    .clk_in   (LINK_CLK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     (m_q.tx_req),
    .q_out    (tx_req_s)
  );
  slp_sync3 u_rxack (
    .clk_in   (LINK_CLK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     (m_q.rx_ack),
    .q_out    (rx_ack_s)
  );

  // ----------------------------------------
  // transmit buffer
  // ----------------------------------------
  slp_buf2 #(
    .W     (BW),
    .DEPTH (2)
  ) u_txbuf (
    .clk_in        (MCLK_IN),
    .rst_n_in      (RST_N_IN),
    .in_valid_in   (buf_in_valid),
    .in_ready_out  (buf_in_ready),
    .in_data_in    (buf_in_data),
    .out_valid_out (head_valid),
    .out_ready_in  (head_ready),
    .out_data_out  (head_data)
  );

  // ----------------------------------------
  // fetch control
  // ----------------------------------------
  // period ends; a full buffer holds the fetch clock low while a captured word waits, until room appears
  assign f_end        = (m_q.fcnt == m_q.flen - 1'b1);
  assign f_wrap       = f_end & (!m_q.cap_vld | buf_in_ready);
  assign mark_rise    = MARKER_INPUT_IN & !m_q.mark_prev;
  assign buf_in_valid = f_end & m_q.cap_vld;
  assign buf_in_data  = {m_q.mark_pend | mark_rise, m_q.cap_par, m_q.cap_word};
  assign head_ready   = m_q.tx_busy & (tx_ack_s == m_q.tx_req);

  // ----------------------------------------
  // receive decode
  // ----------------------------------------
  assign o_free = !m_q.orun | (m_q.ocnt == m_q.olen - 1'b1);
  assign rx_new = (rx_req_s != m_q.rx_ack);
  assign rx_bad = (l_q.h_par != ((^l_q.h_word) ^ `SLP_PAR_ODD));

  // ----------------------------------------
  // main clock domain
  // ----------------------------------------
  always_comb begin
    m_d           = m_q;
    m_d.mark_prev = MARKER_INPUT_IN;

    // operational timer
    // counts from the later of lock and reset release
    if (!lock_s) begin
      m_d.oper_cnt = '0;
      m_d.oper     = 1'b0;
    end else if (m_q.oper_cnt == OPER_C - 1'b1) begin
      m_d.oper = 1'b1;
    end else begin
      m_d.oper_cnt = m_q.oper_cnt + 1'b1;
    end

    // fetch clock and word capture
    if (mark_rise) begin
      m_d.mark_pend = 1'b1;
    end
    // valid is sampled one cycle after the fetch rise, before the next word is taken
    if (m_q.fcnt == VALID_C - 1'b1) begin
      m_d.mode = VALID_IN ? SLP_BURST : SLP_SINGLE;
    end
    if (f_wrap) begin
      m_d.fcnt      = '0;
      m_d.flen      = (m_q.mark_pend | mark_rise) ? MARK_C : NORM_C;
      m_d.mark_pend = 1'b0;
      m_d.cap_vld   = m_q.oper & ((m_q.mode == SLP_BURST) | VALID_IN);
      m_d.cap_word  = PARALLEL_WORD_IN;
      m_d.cap_par   = PARITY_IN;
    end else if (!f_end) begin
      m_d.fcnt = m_q.fcnt + 1'b1;
    end
    m_d.fclk = (m_d.fcnt < (m_d.flen >> 1));

    // transmit handshake toward the link domain
    if (head_ready) begin
      m_d.tx_busy = 1'b0;
    end else if (!m_q.tx_busy && head_valid) begin
      m_d.tx_req  = !m_q.tx_req;
      m_d.tx_busy = 1'b1;
    end

    // receive output clock
    if (m_q.parity_fault_n_cnt != '0) begin
      m_d.parity_fault_n_cnt = m_q.parity_fault_n_cnt - 1'b1;
    end
    if (m_q.orun) begin
      m_d.ocnt = m_q.ocnt + 1'b1;
      if (m_q.ocnt == m_q.olen - 1'b1) begin
        m_d.orun = 1'b0;
      end
    end
    if (o_free && rx_new) begin
      m_d.rx_ack  = !m_q.rx_ack;
      m_d.orun    = 1'b1;
      m_d.ocnt    = '0;
      m_d.olen    = l_q.h_mark ? MARK_C : NORM_C;
      m_d.rx_word = l_q.h_word;
      m_d.rx_par  = l_q.h_par;
      if (l_q.h_mark) begin
        m_d.mark_out = !m_q.mark_out;
      end
      // a pending loss outranks a header clear in the same word
      if (m_q.sync_pend) begin
        m_d.sync_n    = 1'b0;
        m_d.sync_pend = 1'b0;
      end
      if (rx_bad) begin
        m_d.parity_fault_n_cnt = PARITY_FAULT_N_C;
        if (l_q.h_hdr) begin
          m_d.sync_n = 1'b0;
        end else begin
          m_d.sync_pend = 1'b1;
        end
      end else if (l_q.h_hdr && !m_q.sync_pend) begin
        m_d.sync_n = 1'b1;
      end
    end
    // output clock runs only while a word is shown
    m_d.oclk = m_d.orun & (m_d.ocnt < (m_d.olen >> 1));
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      m_q        <= '0;
      m_q.mode   <= SLP_SINGLE;
      m_q.flen   <= NORM_C;
      m_q.olen   <= NORM_C;
      m_q.sync_n <= 1'b1;
    end else begin
      m_q <= m_d;
    end
  end

  // ----------------------------------------
  // link clock domain
  // ----------------------------------------
  always_comb begin
    l_d        = l_q;
    l_d.tx_stb = 1'b0;
    // head word is stable while the request toggle is outstanding
    if (tx_req_s != l_q.tx_ack) begin
      l_d.tx_ack  = tx_req_s;
      l_d.tx_mark = head_data[BW-1];
      l_d.tx_par  = head_data[BW-2];
      l_d.tx_word = head_data[`SLP_WORD_W-1:0];
      l_d.tx_stb  = 1'b1;
    end
    if (l_q.rx_busy && (rx_ack_s == l_q.rx_req)) begin
      l_d.rx_busy = 1'b0;
    end else if (!l_q.rx_busy && RX_STROBE_IN) begin
      l_d.rx_req  = !l_q.rx_req;
      l_d.rx_busy = 1'b1;
      l_d.h_word  = RX_WORD_IN;
      l_d.h_par   = RX_PARITY_IN;
      l_d.h_mark  = RX_MARK_IN;
      l_d.h_hdr   = RX_HEADER_IN;
    end
  end

  always_ff @(posedge LINK_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // ----------------------------------------
  // transmit outputs
  // ----------------------------------------
  assign TX_FETCH_CLOCK_OUT   = m_q.fclk;
  assign TX_OPER_OUT          = m_q.oper;
  assign TX_WORD_OUT          = l_q.tx_word;
  assign TX_PARITY_OUT        = l_q.tx_par;
  assign TX_MARK_OUT          = l_q.tx_mark;
  assign TX_STROBE_OUT        = l_q.tx_stb;

  // ----------------------------------------
  // receive outputs
  // ----------------------------------------
  assign RX_READY_OUT         = !l_q.rx_busy;
  assign RX_OUTPUT_CLOCK_OUT  = m_q.oclk;
  assign RX_PARALLEL_WORD_OUT = m_q.rx_word;
  assign RX_PARITY_OUT        = m_q.rx_par;
  assign MARKER_OUTPUT_OUT    = m_q.mark_out;
  assign PARITY_FAULT_N_OUT   = (m_q.parity_fault_n_cnt == '0);
  assign SYNC_LOSS_N_OUT      = m_q.sync_n;
endmodule

//--- sim/slp_port_checker.sv
/*
  assertions on slp_port: clock shapes, fault flags, start-up time.
  assumes a bind to slp_port; one clock domain.
*/
`timescale 1ns/1ns
module slp_port_checker (
  input wire logic        MCLK_IN,              // clock
  input wire logic        RST_N_IN,             // reset
  input wire logic        LOCK_IN,              // lock
  input wire logic        TX_FETCH_CLOCK_OUT,   // fetch clk
  input wire logic        TX_OPER_OUT,          // oper
  input wire logic        RX_OUTPUT_CLOCK_OUT,  // out clk
  input wire logic [35:0] RX_PARALLEL_WORD_OUT, // rx word
  input wire logic        RX_PARITY_OUT,        // rx parity
  input wire logic        MARKER_OUTPUT_OUT,    // marker
  input wire logic        PARITY_FAULT_N_OUT,   // fault
  input wire logic        SYNC_LOSS_N_OUT       // sync
);
  logic [10:0] lock_cnt_q;

  // --------------------
  // cycles with lock high
  // --------------------
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      lock_cnt_q <= 11'h000;
    end else if (!LOCK_IN) begin
      lock_cnt_q <= 11'h000;
    end else if (lock_cnt_q != 11'h7ff) begin
      lock_cnt_q <= lock_cnt_q + 11'h001;
    end
  end

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence orise_s;
    $rose(RX_OUTPUT_CLOCK_OUT);
  endsequence
  sequence bad_s;
    orise_s ##0 (RX_PARITY_OUT != ^RX_PARALLEL_WORD_OUT);
  endsequence

  fetch_high_a: assert property ($rose(TX_FETCH_CLOCK_OUT) |=> !TX_FETCH_CLOCK_OUT)
    else $error("fetch clock high too long");
  oclk_high_a: assert property (orise_s |=> !RX_OUTPUT_CLOCK_OUT)
    else $error("output clock high too long");
  mark_toggle_a: assert property ($changed(MARKER_OUTPUT_OUT) |-> orise_s)
    else $error("marker moved off a word");
  parity_fault_n_cause_a: assert property (bad_s |-> !PARITY_FAULT_N_OUT)
    else $error("bad parity not flagged");
  parity_fault_n_only_a: assert property ($fell(PARITY_FAULT_N_OUT) |-> bad_s)
    else $error("fault flag without cause");
  parity_fault_n_pulse_a: assert property (!PARITY_FAULT_N_OUT |=> PARITY_FAULT_N_OUT)
    else $error("fault pulse too long");
  sync_edge_a: assert property ($changed(SYNC_LOSS_N_OUT) |-> orise_s)
    else $error("sync flag moved off a word");
  oper_time_a: assert property ($rose(TX_OPER_OUT) |-> lock_cnt_q >= 11'h4e2)
    else $error("operational too early");
endmodule

//--- sim/slp_link_model.sv
/*
  serial core model: collects sent words, offers received words.
  assumes the link clock; changes follow its rising edge.
*/
`timescale 1ns/1ns
module slp_link_model (
  input  wire logic        link_clk_in, // link clock
  input  wire logic [35:0] tx_word_in,  // sent word
  input  wire logic        tx_par_in,   // its parity
  input  wire logic        tx_mark_in,  // its marker
  input  wire logic        tx_stb_in,   // word strobe
  input  wire logic        rx_rdy_in,   // ready
  output logic      [35:0] rx_word_out, // offered word
  output logic             rx_par_out,  // its parity
  output logic             rx_mark_out, // its marker
  output logic             rx_hdr_out,  // header flag
  output logic             rx_stb_out   // word offered
);
  logic [37:0] txq [$];

  initial begin
    rx_word_out = 36'h0;
    rx_par_out = 1'h0;
    rx_mark_out = 1'h0;
    rx_hdr_out = 1'h0;
    rx_stb_out = 1'h0;
  end

  always @(posedge link_clk_in) begin
    if (tx_stb_in === 1'h1) begin
      txq.push_back({tx_mark_in, tx_par_in, tx_word_in});
    end
  end

  // idle cycles first, then the word holds until ready is seen
  task automatic send(input logic [35:0] w, input logic p, m, h, input int idle);
    int n;
    repeat (idle) @(posedge link_clk_in);
    rx_word_out <= w;
    rx_par_out <= p;
    rx_mark_out <= m;
    rx_hdr_out <= h;
    rx_stb_out <= 1'h1;
    n = 0;
    do begin
      @(posedge link_clk_in);
      n++;
    end while (rx_rdy_in !== 1'h1 && n < 100);
    // released fields show the inverse, never a stale copy
    rx_stb_out <= 1'h0;
    rx_word_out <= ~w;
    rx_par_out <= ~p;
    rx_mark_out <= ~m;
    rx_hdr_out <= ~h;
  endtask
endmodule

//--- sim/testbench.sv
/*
  testbench of slp_port: start-up, fetch clock, burst capture, receive faults.
  assumes slp_link_model on the link side; inputs change on falling clock edges.
*/
`timescale 1ns/1ns
module testbench;
  logic        mclk, lclk, rst_n, lock, valid, mk_in, par_in, exp_mk;
  logic        fclk, oper, txp, txm, txs, rxp, rxm, rxh, rxs, rdy, oclk, orp, mko;
  logic        parity_fault_n_n, sync_n;
  logic [35:0] word_in, txw, rxw, orw;
  int          fail_count, compares;

  slp_port dut_u (
    .MCLK_IN(mclk), .RST_N_IN(rst_n), .LINK_CLK_IN(lclk), .LOCK_IN(lock),
    .PARALLEL_WORD_IN(word_in), .PARITY_IN(par_in), .VALID_IN(valid),
    .MARKER_INPUT_IN(mk_in), .TX_FETCH_CLOCK_OUT(fclk), .TX_OPER_OUT(oper),
    .TX_WORD_OUT(txw), .TX_PARITY_OUT(txp), .TX_MARK_OUT(txm), .TX_STROBE_OUT(txs),
    .RX_WORD_IN(rxw), .RX_PARITY_IN(rxp), .RX_MARK_IN(rxm), .RX_HEADER_IN(rxh),
    .RX_STROBE_IN(rxs), .RX_READY_OUT(rdy), .RX_OUTPUT_CLOCK_OUT(oclk),
    .RX_PARALLEL_WORD_OUT(orw), .RX_PARITY_OUT(orp), .MARKER_OUTPUT_OUT(mko),
    .PARITY_FAULT_N_OUT(parity_fault_n_n), .SYNC_LOSS_N_OUT(sync_n)
  );
  slp_link_model link_u (
    .link_clk_in(lclk), .tx_word_in(txw), .tx_par_in(txp), .tx_mark_in(txm),
    .tx_stb_in(txs), .rx_rdy_in(rdy), .rx_word_out(rxw), .rx_par_out(rxp),
    .rx_mark_out(rxm), .rx_hdr_out(rxh), .rx_stb_out(rxs)
  );

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    lclk = 1'h0;
    #7;
    forever #32 lclk = ~lclk;
  end

  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [39:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_fail();
    fail_count++;
    $display("[FAIL] wait limit exp 1 seen 0");
    end_of_test();
  endtask

  function automatic logic [35:0] wv(input int i);
    return 36'h8c3a5f0e1 + 36'h000010101 * 36'(i);
  endfunction

  // main clock cycles up to the next fetch clock rise
  task automatic fetch_gap(output int n);
    logic p;
    p = fclk;
    n = 0;
    forever begin
      @(negedge mclk);
      n++;
      if (!p && fclk) break;
      p = fclk;
      if (n > 200) wait_fail();
    end
  endtask

  // --------------------
  // scenarios
  // --------------------
  task automatic t_reset();
    repeat (12) @(negedge mclk);
    chk("fault in reset", parity_fault_n_n, 1'h1);
    chk("sync in reset", sync_n, 1'h1);
    rst_n = 1'h1;
  endtask

  task automatic t_oper();
    int n;
    repeat (20) @(negedge mclk);
    chk("oper before lock", oper, 1'h0);
    lock = 1'h1;
    valid = 1'h1;
    n = 0;
    while (oper !== 1'h1 && n < 2000) begin
      @(negedge mclk);
      n++;
      if (n == 1200) valid = 1'h0;
    end
    if (n >= 2000) wait_fail();
    chk("lock to oper", (n >= 1250 && n <= 1260), 1'h1);
  endtask

  task automatic t_mark();
    int n;
    fetch_gap(n);
    fetch_gap(n);
    chk("fetch period", n, 2);
    mk_in = 1'h1;
    fetch_gap(n);
    chk("period with mark", n, 2);
    fetch_gap(n);
    chk("stretched period", n, 3);
    mk_in = 1'h0;
    fetch_gap(n);
    chk("period after", n, 2);
    chk("single mode words", link_u.txq.size(), 0);
  endtask

  task automatic t_burst();
    int n;
    for (int i = 0; i <= 4; i++) begin
      fetch_gap(n);
      word_in = wv(i);
      par_in = i[0];
      valid = (i < 4);
      mk_in = (i == 2);
    end
    n = 0;
    while (link_u.txq.size() < 4 && n < 800) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 800) wait_fail();
    repeat (60) @(negedge mclk);
    chk("burst words", link_u.txq.size(), 4);
    for (int i = 0; i < 4; i++) begin
      chk("sent word", link_u.txq[i], {i == 1, i[0], wv(i)});
    end
  endtask

  task automatic t_rx();
    logic [4:0] tb [7] = '{5'h03, 5'h13, 5'h05, 5'h02, 5'h0b, 5'h0c, 5'h0b};
    logic [35:0] w;
    int n;
    for (int i = 0; i < 7; i++) begin
      w = wv(i + 9);
      link_u.send(w, (^w) ^ tb[i][2], tb[i][4], tb[i][3], (i % 2) ? 1 : 6);
      n = 0;
      do begin
        @(negedge mclk);
        n++;
      end while (oclk !== 1'h1 && n < 40);
      if (n >= 40) wait_fail();
      exp_mk = exp_mk ^ tb[i][4];
      chk("rx word", {orp, orw}, {(^w) ^ tb[i][2], w});
      chk("marker out", mko, exp_mk);
      chk("fault flag", parity_fault_n_n, tb[i][1]);
      chk("sync flag", sync_n, tb[i][0]);
    end
  endtask

  initial begin
    rst_n = 1'h0;
    lock = 1'h0;
    valid = 1'h0;
    mk_in = 1'h0;
    par_in = 1'h0;
    word_in = 36'h0;
    exp_mk = 1'h0;
    fail_count = 0;
    compares = 0;
    t_reset();
    t_oper();
    t_mark();
    t_burst();
    t_rx();
    end_of_test();
  end
endmodule

bind slp_port slp_port_checker chk_u (
  .MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .LOCK_IN(LOCK_IN),
  .TX_FETCH_CLOCK_OUT(TX_FETCH_CLOCK_OUT), .TX_OPER_OUT(TX_OPER_OUT),
  .RX_OUTPUT_CLOCK_OUT(RX_OUTPUT_CLOCK_OUT), .RX_PARALLEL_WORD_OUT(RX_PARALLEL_WORD_OUT),
  .RX_PARITY_OUT(RX_PARITY_OUT), .MARKER_OUTPUT_OUT(MARKER_OUTPUT_OUT),
  .PARITY_FAULT_N_OUT(PARITY_FAULT_N_OUT), .SYNC_LOSS_N_OUT(SYNC_LOSS_N_OUT)
);
